// [include/pddg_pkg.sv]
// Package for the pole detection and deviation guard block.
// Assumes a 50 MHz single clock and an Avalon-MM register master.
package pddg_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  // Control cycle of the deviation checks
  localparam int CTRL_PERIOD_NS = 1000;
  localparam int CTRL_DIV       = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  // Duration of one pole detection run
  localparam int DETECT_TIME_MS = 100;
  localparam int DETECT_CYC_DEF = DETECT_TIME_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] OFF_POLE_EN = 6'h00;
  localparam logic [5:0] OFF_DEV_SEL = 6'h04;
  localparam logic [5:0] OFF_POS_LVL = 6'h08;
  localparam logic [5:0] OFF_SPD_LVL = 6'h0C;
  localparam logic [5:0] OFF_TRQ_LVL = 6'h10;
  localparam logic [5:0] OFF_METHOD  = 6'h14;
  localparam logic [5:0] OFF_VOLT    = 6'h18;
  localparam logic [5:0] OFF_CFG     = 6'h1C;
  localparam logic [5:0] OFF_STATUS  = 6'h20;
  localparam logic [5:0] OFF_MASK    = 6'h24;
  localparam logic [5:0] OFF_STATE   = 6'h28;

  // ==========================================================
  // Field positions
  localparam int POLE_EN_BIT = 0;
  localparam int METHOD_BIT  = 0;  // 0 position, 1 minute position
  localparam int ABS_BIT     = 0;  // 0 incremental, 1 absolute
  localparam int DEV_POS_BIT = 0;
  localparam int DEV_SPD_BIT = 1;
  localparam int DEV_TRQ_BIT = 2;
  // Status and mask layout
  localparam int EV_DONE  = 0;
  localparam int EV_POLE  = 1;
  localparam int EV_POS   = 2;
  localparam int EV_SPD   = 3;
  localparam int EV_TRQ   = 4;
  localparam int EV_ABORT = 5;
  localparam int EV_W     = 6;

  // ==========================================================
  // Widths, ranges and reset values
  localparam int POS_LW = 10;
  localparam int SPD_LW = 11;
  localparam int TRQ_LW = 10;
  localparam int VOLT_W = 8;
  localparam logic [POS_LW-1:0] POS_MIN = 10'h001;
  localparam logic [POS_LW-1:0] POS_MAX = 10'h3E8;  // 1000 x 0.01 rev
  localparam logic [POS_LW-1:0] POS_RST = 10'h009;  // 0.09 rev
  localparam logic [SPD_LW-1:0] SPD_MIN = 11'h001;
  localparam logic [SPD_LW-1:0] SPD_MAX = 11'h7D0;  // 2000 r/min
  localparam logic [SPD_LW-1:0] SPD_RST = 11'h064;  // 100 r/min
  localparam logic [TRQ_LW-1:0] TRQ_MIN = 10'h001;
  localparam logic [TRQ_LW-1:0] TRQ_MAX = 10'h3E8;  // 1000 %
  localparam logic [TRQ_LW-1:0] TRQ_RST = 10'h064;  // 100 %
  localparam logic [2:0]        DEV_RST = 3'h3;
  localparam logic              POLE_EN_RST = 1'b1;
  localparam logic [VOLT_W-1:0] VOLT_RST = 8'h1E;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PD_IDLE, PD_DETECT, PD_ON, PD_FAULT
  } pddg_state_e;

  typedef struct packed {
    logic signed [31:0] model_pos;  // 0.01 rev units
    logic signed [31:0] fb_pos;
    logic signed [15:0] model_spd;  // r/min
    logic signed [15:0] fb_spd;
    logic signed [15:0] cmd_trq;    // percent of rating
    logic signed [15:0] fb_trq;
  } pddg_fb_s;

  typedef struct packed {
    logic overload_alarm_one;
    logic overload_alarm_two;
    logic overload_warning_one;
    logic overload_warning_two;
  } pddg_ovl_s;

  typedef struct packed {
    logic initial_pole_detect_alarm;
    logic position_deviation_alarm;
    logic speed_deviation_alarm;
    logic torque_deviation_alarm;
  } pddg_alm_s;

endpackage

// [rtl/pddg_dev_cmp.sv]
// One deviation comparator: trips when |a - b| exceeds a level.
// Assumes a and b are signed and tick marks one control cycle.
`timescale 1ns/1ns
module pddg_dev_cmp #(
  parameter int W  = 32,
  parameter int LW = 10
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Evaluation
  input  wire logic                tick,
  input  wire logic                en,
  input  wire logic signed [W-1:0] a,
  input  wire logic signed [W-1:0] b,
  input  wire logic [LW-1:0]       level,
  // Result
  output logic                     trip
);

  logic signed [W:0] diff;
  logic [W:0]        mag;
  logic [W:0]        lvl_ext;

  // One extra bit so extreme operands cannot wrap
  assign diff    = {a[W-1], a} - {b[W-1], b};
  assign mag     = diff[W] ? (W+1)'(-diff) : (W+1)'(diff);
  assign lvl_ext = {{(W+1-LW){1'b0}}, level};

  // Sampled once per control cycle; a disabled check clears at once,
  // so a stale trip cannot fire again when the check is re-enabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip <= 1'b0;
    end else if (!en) begin
      trip <= 1'b0;
    end else if (tick) begin
      trip <= mag > lvl_ext;
    end
  end

endmodule

// [rtl/pddg_top.sv]
// Pole detection sequencer and servo control deviation guard.
// Assumes synchronous inputs, one 50 MHz clock, Avalon-MM master.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// - Incremental setup detects poles at first servo-on after power-up.
// - A stroke limit dropping mid-detection reverses detection direction.
// - Both stroke limits off raises the initial pole detection alarm.
// - Enable bit 1 (default) detects at first servo-on; 0 disables it in absolute setup only.
// - Method bit picks position or minute position detection.
// - Voltage level drives only the position detection method.
// - Overload during test-run detection ends it and turns servo off.
// - Deviation select resets to 3, position and speed checks on.
// - Select bit value 1 enables the position deviation check.
// - Position deviation over level raises its alarm and stops.
// - Position level spans 1 to 1000 of 0.01 rev, reset 0.09 rev.
// - Select bit value 2 enables the speed deviation check.
// - Speed deviation over level raises its alarm and stops.
// - Select bit value 4 enables the torque deviation check.
// - Torque deviation over level raises its alarm and stops.
module pddg_top
  import pddg_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_CYC_DEF
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Avalon-MM slave
  input  wire logic [5:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  output logic                       irq,
  // Controller and machine side
  input  wire logic                  servo_on_cmd,
  input  wire logic                  test_mode,
  input  wire logic                  forward_stroke_limit,
  input  wire logic                  reverse_stroke_limit,
  input  wire pddg_pkg::pddg_ovl_s   overload,
  input  wire pddg_pkg::pddg_fb_s    fb,
  // Drive side
  output logic                       servo_ready,
  output logic                       motor_stop,
  output logic                       detect_active,
  output logic                       detect_reverse,
  output logic                       detect_minute,
  output logic [VOLT_W-1:0]          detect_drive_level,
  output pddg_pkg::pddg_alm_s        alarm
);
  import pddg_pkg::*;

  // ==========================================================
  // Registers
  logic                 pole_en;
  logic [2:0]           dev_sel;
  logic [POS_LW-1:0]    pos_lvl;
  logic [SPD_LW-1:0]    spd_lvl;
  logic [TRQ_LW-1:0]    trq_lvl;
  logic                 method;
  logic [VOLT_W-1:0]    volt;
  logic                 abs_cfg;
  logic [EV_W-1:0]      status;
  logic [EV_W-1:0]      mask;
  logic                 ack;
  pddg_state_e          state;
  pddg_state_e          next_state;
  logic                 pending;
  logic [31:0]          det_cnt;
  logic [15:0]          div_cnt;
  logic                 tick;
  logic                 fwd_q;
  logic                 rev_q;
  logic                 trip_pos;
  logic                 trip_spd;
  logic                 trip_trq;

  // ==========================================================
  // Bus decode
  logic        req;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_mux;
  logic        rd_status;
  assign req       = read | write;
  // Every access takes two edges; the slave answers on the second
  assign waitrequest = req & ~ack;
  assign wr_hit    = write & ack;
  assign rd_status = read & ack & (address == OFF_STATUS);

  // Read data selection, unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address)
      OFF_POLE_EN: rd_mux[POLE_EN_BIT] = pole_en;
      OFF_DEV_SEL: rd_mux[2:0] = dev_sel;
      OFF_POS_LVL: rd_mux[POS_LW-1:0] = pos_lvl;
      OFF_SPD_LVL: rd_mux[SPD_LW-1:0] = spd_lvl;
      OFF_TRQ_LVL: rd_mux[TRQ_LW-1:0] = trq_lvl;
      OFF_METHOD:  rd_mux[METHOD_BIT] = method;
      OFF_VOLT:    rd_mux[VOLT_W-1:0] = volt;
      OFF_CFG:     rd_mux[ABS_BIT] = abs_cfg;
      OFF_STATUS:  rd_mux[EV_W-1:0] = status;
      OFF_MASK:    rd_mux[EV_W-1:0] = mask;
      OFF_STATE:   rd_mux[1:0] = 2'(state);
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // Handshake: ack marks the edge at which the master samples
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (read & ~ack) begin
        readdata <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Level clamping keeps every threshold inside its legal span
  logic [POS_LW-1:0] wr_pos;
  logic [SPD_LW-1:0] wr_spd;
  logic [TRQ_LW-1:0] wr_trq;
  assign wr_pos = (writedata < 32'(POS_MIN)) ? POS_MIN :
                  (writedata > 32'(POS_MAX)) ? POS_MAX :
                  writedata[POS_LW-1:0];
  assign wr_spd = (writedata < 32'(SPD_MIN)) ? SPD_MIN :
                  (writedata > 32'(SPD_MAX)) ? SPD_MAX :
                  writedata[SPD_LW-1:0];
  assign wr_trq = (writedata < 32'(TRQ_MIN)) ? TRQ_MIN :
                  (writedata > 32'(TRQ_MAX)) ? TRQ_MAX :
                  writedata[TRQ_LW-1:0];

  // Configuration writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pole_en <= POLE_EN_RST;
      dev_sel <= DEV_RST;
      pos_lvl <= POS_RST;
      spd_lvl <= SPD_RST;
      trq_lvl <= TRQ_RST;
      method  <= 1'b0;
      volt    <= VOLT_RST;
      abs_cfg <= 1'b0;
      mask    <= '0;
    end else if (wr_hit) begin
      case (address)
        OFF_POLE_EN: pole_en <= writedata[POLE_EN_BIT];
        OFF_DEV_SEL: dev_sel <= writedata[2:0];
        OFF_POS_LVL: pos_lvl <= wr_pos;
        OFF_SPD_LVL: spd_lvl <= wr_spd;
        OFF_TRQ_LVL: trq_lvl <= wr_trq;
        OFF_METHOD:  method  <= writedata[METHOD_BIT];
        OFF_VOLT:    volt    <= writedata[VOLT_W-1:0];
        OFF_CFG:     abs_cfg <= writedata[ABS_BIT];
        OFF_MASK:    mask    <= writedata[EV_W-1:0];
        default:     ;
      endcase
    end
  end

  // ==========================================================
  // Control cycle divider
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == 16'(CTRL_DIV - 1));
      div_cnt <= (div_cnt == 16'(CTRL_DIV - 1)) ? '0 : div_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Deviation checks
  logic chk_on;
  assign chk_on = (state == PD_ON) || (state == PD_DETECT);

  pddg_dev_cmp #(.W(32), .LW(POS_LW)) u_pos (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (tick),
    .en    (chk_on && dev_sel[DEV_POS_BIT]),
    .a     (fb.model_pos),
    .b     (fb.fb_pos),
    .level (pos_lvl),
    .trip  (trip_pos)
  );
  pddg_dev_cmp #(.W(16), .LW(SPD_LW)) u_spd (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (tick),
    .en    (chk_on && dev_sel[DEV_SPD_BIT]),
    .a     (fb.model_spd),
    .b     (fb.fb_spd),
    .level (spd_lvl),
    .trip  (trip_spd)
  );
  pddg_dev_cmp #(.W(16), .LW(TRQ_LW)) u_trq (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (tick),
    .en    (chk_on && dev_sel[DEV_TRQ_BIT]),
    .a     (fb.cmd_trq),
    .b     (fb.fb_trq),
    .level (trq_lvl),
    .trip  (trip_trq)
  );

  // ==========================================================
  // Pole detection sequencing
  logic need_detect;
  logic both_off;
  logic ovl_any;
  logic det_end;
  logic any_trip;
  logic test_abort;
  // incremental always detects once; absolute obeys bit
  assign need_detect = pending && (!abs_cfg || pole_en);
  assign both_off   = !forward_stroke_limit && !reverse_stroke_limit;
  assign ovl_any    = |overload;
  assign test_abort = (state == PD_DETECT) && test_mode && ovl_any;
  assign det_end    = det_cnt == 32'(DETECT_CYCLES - 1);
  // any single check is enough to stop
  assign any_trip   = trip_pos | trip_spd | trip_trq;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      PD_IDLE: begin
        if (servo_on_cmd) begin
          next_state = need_detect ? PD_DETECT : PD_ON;
        end
      end
      PD_DETECT: begin
        // abort holds servo off until the command is dropped
        if (!servo_on_cmd) begin
          next_state = PD_IDLE;
        end else if (both_off || any_trip || test_abort) begin
          next_state = PD_FAULT;
        end else if (det_end) begin
          next_state = PD_ON;
        end
      end
      PD_ON: begin
        if (!servo_on_cmd) begin
          next_state = PD_IDLE;
        end else if (any_trip) begin
          next_state = PD_FAULT;
        end
      end
      PD_FAULT: begin
        // Alarm holds until the controller drops servo-on
        if (!servo_on_cmd) begin
          next_state = PD_IDLE;
        end
      end
      default: next_state = PD_IDLE;
    endcase
  end

  // State, detection timer and direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state          <= PD_IDLE;
      pending        <= 1'b1;
      det_cnt        <= '0;
      detect_reverse <= 1'b0;
      fwd_q          <= 1'b0;
      rev_q          <= 1'b0;
    end else begin
      state <= next_state;
      fwd_q <= forward_stroke_limit;
      rev_q <= reverse_stroke_limit;
      if (state == PD_DETECT && next_state == PD_ON) begin
        pending <= 1'b0;
      end
      if (state != PD_DETECT) begin
        det_cnt        <= '0;
        // Start away from a limit that is already off
        detect_reverse <= !forward_stroke_limit;
      end else begin
        det_cnt <= det_cnt + 32'h0000_0001;
        if (fwd_q && !forward_stroke_limit) begin
          detect_reverse <= 1'b1;
        end else if (rev_q && !reverse_stroke_limit) begin
          detect_reverse <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Alarms latch until servo-on is dropped; set wins
  logic pole_alarm_set;
  assign pole_alarm_set = (state == PD_DETECT) && both_off;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm <= '0;
    end else begin
      alarm.initial_pole_detect_alarm <= pole_alarm_set ||
        (alarm.initial_pole_detect_alarm && servo_on_cmd);
      alarm.position_deviation_alarm <= trip_pos ||
        (alarm.position_deviation_alarm && servo_on_cmd);
      alarm.speed_deviation_alarm <= trip_spd ||
        (alarm.speed_deviation_alarm && servo_on_cmd);
      alarm.torque_deviation_alarm <= trip_trq ||
        (alarm.torque_deviation_alarm && servo_on_cmd);
    end
  end

  // ==========================================================
  // Sticky status, cleared by reading it; a new event wins
  logic [EV_W-1:0] events;
  assign events[EV_DONE]  = (state == PD_DETECT) && (next_state == PD_ON);
  assign events[EV_POLE]  = pole_alarm_set;
  assign events[EV_POS]   = trip_pos;
  assign events[EV_SPD]   = trip_spd;
  assign events[EV_TRQ]   = trip_trq;
  assign events[EV_ABORT] = test_abort;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status <= (rd_status ? '0 : status) | events;
    end
  end
  assign irq = |(status & mask);

  // ==========================================================
  // Drive outputs
  // ready only in PD_ON, after detection or when none is needed
  assign servo_ready   = (state == PD_ON);
  assign motor_stop    = (state == PD_FAULT);
  assign detect_active = (state == PD_DETECT);
  assign detect_minute = method;
  assign detect_drive_level = (detect_active && !method) ? volt : '0;

endmodule

// [sim/pddg_ctrl_model.sv]
// Motion controller model: servo-on level and positioning start.
// Assumes the bench asks for servo-on through want_on.
`timescale 1ns/1ns
module pddg_ctrl_model (
  // Clock and reset
  input wire logic  clk,
  input wire logic  nrst,
  // Bench request and device answer
  input wire logic  want_on,
  input wire logic  servo_ready,
  // Commands to the device
  output logic      servo_on_cmd,
  output logic      move_cmd
);
  // positioning interlocked on ready, since detection comes first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      servo_on_cmd <= 1'b0;
      move_cmd     <= 1'b0;
    end else begin
      servo_on_cmd <= want_on;
      move_cmd     <= want_on && servo_on_cmd && servo_ready;
    end
  end
endmodule

// [sim/pddg_top_sva.sv]
// Port checker for the pole detection and deviation guard.
// Assumes one clock and an active-low async reset; bound below.
`timescale 1ns/1ns
module pddg_top_sva #(
  parameter int DETECT_CYCLES = 20
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         nrst,
  // Machine side
  input wire logic                         test_mode,
  input wire logic                         forward_stroke_limit,
  input wire logic                         reverse_stroke_limit,
  input wire pddg_pkg::pddg_ovl_s          overload,
  // Drive side
  input wire logic                         servo_ready,
  input wire logic                         motor_stop,
  input wire logic                         detect_active,
  input wire logic                         detect_reverse,
  input wire logic                         detect_minute,
  input wire logic [pddg_pkg::VOLT_W-1:0]  detect_drive_level,
  input wire pddg_pkg::pddg_alm_s          alarm
);
  import pddg_pkg::*;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  logic [31:0] det_cnt;

  // ======
  // Run length counter, too long for a repetition
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) det_cnt <= '0;
    else det_cnt <= detect_active ? det_cnt + 32'h1 : '0;
  end

  // Steps the rules react to
  sequence s_both_off;
    detect_active && !forward_stroke_limit && !reverse_stroke_limit;
  endsequence
  sequence s_ovl_hit;
    detect_active && test_mode && (overload != '0);
  endsequence
  sequence s_no_drive;
    (detect_minute || !detect_active) [*2];
  endsequence

  // ======
  // Assertions
  chk_detect_bound: assert property (
    det_cnt <= DETECT_CYCLES + 2) else $error("detection overran");
  chk_fwd_reverses: assert property (
    detect_active && $fell(forward_stroke_limit) && reverse_stroke_limit
    |=> detect_reverse) else $error("no reverse after forward drop");
  chk_rev_forwards: assert property (
    detect_active && $fell(reverse_stroke_limit) && forward_stroke_limit
    |=> !detect_reverse) else $error("no forward after reverse drop");
  chk_both_off_alarm: assert property (
    s_both_off |=> alarm.initial_pole_detect_alarm && motor_stop)
    else $error("both limits off gave no alarm");
  chk_pole_alarm_cause: assert property (
    $rose(alarm.initial_pole_detect_alarm) |-> $past(detect_active)
    && !$past(forward_stroke_limit) && !$past(reverse_stroke_limit))
    else $error("pole alarm without cause");
  chk_overload_abort: assert property (
    s_ovl_hit |=> !detect_active && !servo_ready)
    else $error("overload did not end detection");
  chk_minute_no_drive: assert property (
    s_no_drive |-> detect_drive_level == '0)
    else $error("drive level outside position method");
  chk_dev_stop: assert property (
    $rose(alarm.position_deviation_alarm || alarm.speed_deviation_alarm
    || alarm.torque_deviation_alarm) |-> ##[0:2] motor_stop)
    else $error("deviation alarm did not stop");
endmodule

bind pddg_top pddg_top_sva #(.DETECT_CYCLES(DETECT_CYCLES)) u_sva (
  .clk, .nrst, .test_mode, .forward_stroke_limit, .reverse_stroke_limit,
  .overload, .servo_ready, .motor_stop, .detect_active, .detect_reverse,
  .detect_minute, .detect_drive_level, .alarm);

// [sim/tb_pole_detect_deviation_guard.sv]
// Self-checking bench for the pole detection and deviation guard.
// Assumes the checker and the controller model are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
`define WAIT_UNTIL(c, n) begin wk = 0; while (!(c) && wk < (n)) begin \
  @(negedge clk); wk++; end if (wk >= (n)) begin n_errors++; \
  $display("[FAIL] t=%0t wait ran out", $time); stop_test(); end end
module tb_pole_detect_deviation_guard;
  import pddg_pkg::*;
  localparam int DCYC = 20;
  logic              clk, nrst, read, write, waitrequest, irq;
  logic [5:0]        address;
  logic [31:0]       writedata, readdata, rd;
  logic              servo_on_cmd, test_mode, want_on, move_cmd;
  logic              forward_stroke_limit, reverse_stroke_limit;
  pddg_ovl_s         overload;
  pddg_fb_s          fb;
  logic              servo_ready, motor_stop, detect_active;
  logic              detect_reverse, detect_minute;
  logic [VOLT_W-1:0] detect_drive_level;
  pddg_alm_s         alarm;
  int                n_errors, tests_run, wk;
  logic [5:0]        offs [7] = '{OFF_POLE_EN, OFF_DEV_SEL, OFF_POS_LVL,
                                  OFF_SPD_LVL, OFF_TRQ_LVL, OFF_MASK, 6'h3C};
  logic [31:0]       rstv [7] = '{32'h1, 32'h3, 32'h9, 32'h64, 32'h64,
                                  32'h0, 32'h0};

  pddg_top #(.DETECT_CYCLES(DCYC)) uut (.clk, .nrst, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .irq, .servo_on_cmd,
    .test_mode, .forward_stroke_limit, .reverse_stroke_limit, .overload,
    .fb, .servo_ready, .motor_stop, .detect_active, .detect_reverse,
    .detect_minute, .detect_drive_level, .alarm);
  pddg_ctrl_model u_ctrl (.clk, .nrst, .want_on, .servo_ready,
    .servo_on_cmd, .move_cmd);

  // ======
  // Helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One Avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= we;
    read      <= !we;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    if (i >= 50) begin
      n_errors++;
      $display("[FAIL] t=%0t bus timed out", $time);
      stop_test();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // Random bases with a signed offset on each compared pair
  task automatic setdev(input int dp, input int ds, input int dt);
    pddg_fb_s v;
    v.model_pos = 32'($urandom_range(0, 65535));
    v.fb_pos    = v.model_pos + (($urandom & 1) ? dp : -dp);
    v.model_spd = 16'($urandom_range(0, 999));
    v.fb_spd    = v.model_spd + 16'(($urandom & 1) ? ds : -ds);
    v.cmd_trq   = 16'($urandom_range(0, 999));
    v.fb_trq    = v.cmd_trq + 16'(($urandom & 1) ? dt : -dt);
    @(posedge clk);
    fb <= v;
  endtask

  function automatic logic [31:0] clamp(input int v, input int hi);
    return (v < 1) ? 32'h1 : (v > hi) ? 32'(hi) : 32'(v);
  endfunction

  function automatic logic [3:0] exp_alarm(input int k);
    return (k == 3) ? 4'h7 : 4'h4 >> k;
  endfunction

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ======
  // Main sequence
  initial begin
    int pv [3];
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    want_on = 1'b0; test_mode = 1'b0; overload = '0; fb = '0;
    forward_stroke_limit = 1'b1; reverse_stroke_limit = 1'b1;
    n_errors = 0; tests_run = 0;
    void'($urandom(32'hE4EA));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // reset values, clamping of the position level
    foreach (offs[i]) begin
      bus(1'b0, offs[i], '0, rd);
      `CHK(rd, rstv[i])
    end
    pv = '{0, 2000, $urandom_range(1, 1000)};
    foreach (pv[i]) begin
      bus(1'b1, OFF_POS_LVL, 32'(pv[i]), rd);
      bus(1'b0, OFF_POS_LVL, '0, rd);
      `CHK(rd, clamp(pv[i], 1000))
    end
    bus(1'b1, OFF_POS_LVL, 32'(POS_RST), rd);
    tdone("registers");
    // tuned level, 70 percent of an alarm level of 70
    bus(1'b1, OFF_VOLT, 32'h31, rd);
    @(posedge clk); want_on <= 1'b1;
    `WAIT_UNTIL(detect_active === 1'b1, 10)
    `CHK(detect_active, 1'b1)
    `CHK(detect_minute, 1'b0)
    `CHK(detect_drive_level, 8'h31)
    @(posedge clk); forward_stroke_limit <= 1'b0;
    reverse_stroke_limit <= 1'b0;
    `WAIT_UNTIL(alarm.initial_pole_detect_alarm === 1'b1, 5)
    `CHK(motor_stop, 1'b1)
    @(posedge clk); want_on <= 1'b0; test_mode <= 1'b1;
    forward_stroke_limit <= 1'b1; reverse_stroke_limit <= 1'b1;
    `WAIT_UNTIL(alarm === 4'h0 && motor_stop === 1'b0, 10)
    tdone("pole alarm");
    // every overload code ends a test-run detection
    for (int k = 0; k < 4; k++) begin
      @(posedge clk); want_on <= 1'b1;
      `WAIT_UNTIL(detect_active === 1'b1, 10)
      @(posedge clk); overload <= 4'h1 << k;
      `WAIT_UNTIL(detect_active === 1'b0, 5)
      `CHK(servo_ready, 1'b0)
      @(posedge clk); overload <= '0; want_on <= 1'b0;
      repeat (3) @(posedge clk);
    end
    test_mode <= 1'b0;
    tdone("overload");
    // absolute setup with detection disabled goes straight on
    bus(1'b1, OFF_CFG, 32'h1, rd);
    bus(1'b1, OFF_POLE_EN, 32'h0, rd);
    @(posedge clk); want_on <= 1'b1;
    `WAIT_UNTIL(servo_ready === 1'b1, 10)
    `CHK(detect_active, 1'b0)
    @(posedge clk); want_on <= 1'b0;
    bus(1'b1, OFF_POLE_EN, 32'h1, rd);
    bus(1'b1, OFF_METHOD, 32'h1, rd);
    @(posedge clk); want_on <= 1'b1;
    `WAIT_UNTIL(detect_active === 1'b1, 10)
    `CHK(detect_minute, 1'b1)
    `CHK(detect_drive_level, 8'h00)
    // a dropped limit turns the detection round
    @(posedge clk); forward_stroke_limit <= 1'b0;
    `WAIT_UNTIL(detect_reverse === 1'b1, 3)
    `CHK(detect_active, 1'b1)
    @(posedge clk); forward_stroke_limit <= 1'b1;
    reverse_stroke_limit <= 1'b0;
    `WAIT_UNTIL(detect_reverse === 1'b0, 3)
    @(posedge clk); reverse_stroke_limit <= 1'b1;
    `WAIT_UNTIL(servo_ready === 1'b1, 40)
    @(negedge clk);
    `CHK(move_cmd, 1'b1)
    bus(1'b1, OFF_POLE_EN, 32'h0, rd);
    tdone("detection");
    // a deviation equal to the level does not trip
    bus(1'b1, OFF_DEV_SEL, 32'h7, rd);
    setdev(POS_RST, SPD_RST, TRQ_RST);
    repeat (150) @(negedge clk);
    `CHK(alarm, 4'h0)
    // each check alone, then all together, every pair over level
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, OFF_DEV_SEL, (k == 3) ? 32'h7 : 32'h1 << k, rd);
      setdev(POS_RST + 1 + $urandom_range(0, 20),
             SPD_RST + 1 + $urandom_range(0, 20),
             TRQ_RST + 1 + $urandom_range(0, 20));
      `WAIT_UNTIL(alarm !== 4'h0, 120)
      @(negedge clk);
      `CHK(alarm, exp_alarm(k))
      `CHK(motor_stop, 1'b1)
      `CHK(irq, 1'b0)
      bus(1'b1, OFF_MASK, 32'h3F, rd);
      @(negedge clk);
      `CHK(irq, 1'b1)
      bus(1'b0, OFF_STATUS, '0, rd);
      `CHK({rd[EV_POS], rd[EV_SPD], rd[EV_TRQ]}, exp_alarm(k))
      @(negedge clk);
      `CHK(irq, 1'b0)
      bus(1'b1, OFF_MASK, 32'h0, rd);
      setdev(0, 0, 0);
      @(posedge clk); want_on <= 1'b0;
      `WAIT_UNTIL(alarm === 4'h0, 10)
      @(posedge clk); want_on <= 1'b1;
      `WAIT_UNTIL(servo_ready === 1'b1, 10)
    end
    tdone("deviation");
    stop_test();
  end
endmodule
